// ### scfg_decoder.v
// byte-stream decoder of the write-only configuration register map
// assumes: bytes arrive as a same-clock valid strobe from any host interface front end
`timescale 1ns/10ps
`default_nettype none
`include "scfg_map.vh"
module scfg_decoder
(
    input  wire        ref_clk,
    input  wire        rst,
    input  wire        byteValid,
    input  wire [7:0]  byteData,
    input  wire        frameStart,
    output wire        byteReady,
    output wire        busy,
    output wire [39:0] outputToneHz,
    output wire        toneOrSweepSelect,
    output wire [15:0] listPointCount,
    output reg  [39:0] listPointData,
    output reg         listPointStrobe,
    output reg         listMemoryTransfer,
    output reg         listSoftwareTrigger,
    output wire [15:0] outputPowerLevel,
    output wire        outputOnSwitch,
    output wire [15:0] outputPhaseTenths,
    output wire        levelAutoOff,
    output wire        levelingLoopSelect,
    output wire        mainChannelSleep,
    output wire [1:0]  timebaseSelect,
    output wire [13:0] timebaseTrimValue,
    output wire [13:0] levelingTrimValue,
    output reg         savePowerOnState,
    output wire        secondChannelSleep,
    output wire [15:0] secondChannelToneMhz,
    output reg         restartKeep,
    output reg         restartFactory
);
    // ------------------------------------------------------------
    // frame parser
    // ------------------------------------------------------------
    localparam ST_ADDR = 1'b0;
    localparam ST_DATA = 1'b1;

    reg        state_reg;
    reg [7:0]  addr_reg;
    reg [2:0]  cnt_reg;
    reg [39:0] shift_reg;
    reg [2:0]  lenNext;
    reg [39:0] shiftNext;
    reg        done;

    assign byteReady = 1'b1;
    assign busy      = (state_reg == ST_DATA);

    // payload length by address; unmapped addresses take one byte
    always @*
    begin
        case (byteData)
            `SCFG_ADDR_LIST_COUNT, `SCFG_ADDR_POWER, `SCFG_ADDR_PHASE,
            `SCFG_ADDR_TB_TRIM, `SCFG_ADDR_ALC_TRIM, `SCFG_ADDR_CH2_MHZ:
                lenNext = `SCFG_LEN_2;
            `SCFG_ADDR_LIST_LOAD, `SCFG_ADDR_TONE_HZ:
                lenNext = `SCFG_LEN_5;
            `SCFG_ADDR_LIST_START, `SCFG_ADDR_LIST_STOP, `SCFG_ADDR_LIST_STEP:
                lenNext = `SCFG_LEN_5;
            `SCFG_ADDR_LIST_DWELL, `SCFG_ADDR_LIST_CYCLES:
                lenNext = `SCFG_LEN_4;
            default:
                lenNext = `SCFG_LEN_1;
        endcase
    end

    // little-endian assembly: byte k lands in bits 8k+7:8k
    always @*
    begin
        shiftNext = shift_reg;
        case (cnt_reg)
            3'h0: shiftNext[7:0]   = byteData;
            3'h1: shiftNext[15:8]  = byteData;
            3'h2: shiftNext[23:16] = byteData;
            3'h3: shiftNext[31:24] = byteData;
            default: shiftNext[39:32] = byteData;
        endcase
    end

    reg [2:0] len_reg;
    always @(posedge ref_clk)
    begin
        if (rst || frameStart)
        begin
            state_reg <= ST_ADDR;
            addr_reg  <= 8'h00;
            cnt_reg   <= 3'h0;
            len_reg   <= `SCFG_LEN_1;
            shift_reg <= 40'h0000000000;
        end
        else if (byteValid)
        begin
            case (state_reg)
                ST_ADDR:
                begin
                    addr_reg  <= byteData;
                    len_reg   <= lenNext;
                    cnt_reg   <= 3'h0;
                    shift_reg <= 40'h0000000000;
                    state_reg <= ST_DATA;
                end
                ST_DATA:
                begin
                    shift_reg <= shiftNext;
                    cnt_reg   <= cnt_reg + 3'h1;
                    if (cnt_reg + 3'h1 == len_reg)
                        state_reg <= ST_ADDR;
                end
                default:
                    state_reg <= ST_ADDR;
            endcase
        end
    end

    // last payload byte completes the write
    always @*
    begin
        done = byteValid && !frameStart && (state_reg == ST_DATA) && (cnt_reg + 3'h1 == len_reg);
    end

    // ------------------------------------------------------------
    // write selects (same map for every host interface)
    // ------------------------------------------------------------
    wire hit        = done;
    wire selMode    = hit && (addr_reg == `SCFG_ADDR_TONE_MODE);
    wire selCount   = hit && (addr_reg == `SCFG_ADDR_LIST_COUNT);
    wire selLoad    = hit && (addr_reg == `SCFG_ADDR_LIST_LOAD);
    wire selXfer    = hit && (addr_reg == `SCFG_ADDR_LIST_XFER);
    wire selTrig    = hit && (addr_reg == `SCFG_ADDR_LIST_TRIG);
    wire selPower   = hit && (addr_reg == `SCFG_ADDR_POWER);
    wire selOutOn   = hit && (addr_reg == `SCFG_ADDR_OUT_ON);
    wire selPhase   = hit && (addr_reg == `SCFG_ADDR_PHASE);
    wire selAuto    = hit && (addr_reg == `SCFG_ADDR_AUTO_OFF);
    wire selAlc     = hit && (addr_reg == `SCFG_ADDR_ALC_SEL);
    wire selSleep   = hit && (addr_reg == `SCFG_ADDR_MAIN_SLEEP);
    wire selTbSel   = hit && (addr_reg == `SCFG_ADDR_TB_SEL);
    wire selTbTrim  = hit && (addr_reg == `SCFG_ADDR_TB_TRIM);
    wire selAlcTrim = hit && (addr_reg == `SCFG_ADDR_ALC_TRIM);
    wire selSave    = hit && (addr_reg == `SCFG_ADDR_SAVE);
    wire selCh2Slp  = hit && (addr_reg == `SCFG_ADDR_CH2_SLEEP);
    wire selCh2Mhz  = hit && (addr_reg == `SCFG_ADDR_CH2_MHZ);
    wire selRestart = hit && (addr_reg == `SCFG_ADDR_RESTART);
    // sweep mode drops tone writes
    wire toneWr     = hit && (addr_reg == `SCFG_ADDR_TONE_HZ) && !toneOrSweepSelect;
    wire factoryNow = restartFactory;

    // ------------------------------------------------------------
    // field registers
    // ------------------------------------------------------------
    scfg_field_reg #(.W(40), .RST(`SCFG_RST_TONE_HZ)) uTone (
        .ref_clk (ref_clk), .rst (rst), .factory (factoryNow),
        .load (toneWr), .din (shiftNext), .q (outputToneHz));
    scfg_field_reg #(.W(1), .RST(`SCFG_RST_BIT)) uMode (
        .ref_clk (ref_clk), .rst (rst), .factory (factoryNow),
        .load (selMode), .din (shiftNext[0]), .q (toneOrSweepSelect));
    scfg_field_reg #(.W(16), .RST(`SCFG_RST_WORD16)) uCount (
        .ref_clk (ref_clk), .rst (rst), .factory (factoryNow),
        .load (selCount), .din (shiftNext[15:0]), .q (listPointCount));
    scfg_field_reg #(.W(16), .RST(`SCFG_RST_WORD16)) uPower (
        .ref_clk (ref_clk), .rst (rst), .factory (factoryNow),
        .load (selPower), .din (shiftNext[15:0]), .q (outputPowerLevel));
    scfg_field_reg #(.W(1), .RST(`SCFG_RST_OUT_ON)) uOutOn (
        .ref_clk (ref_clk), .rst (rst), .factory (factoryNow),
        .load (selOutOn), .din (shiftNext[0]), .q (outputOnSwitch));
    scfg_field_reg #(.W(16), .RST(`SCFG_RST_WORD16)) uPhase (
        .ref_clk (ref_clk), .rst (rst), .factory (factoryNow),
        .load (selPhase), .din (shiftNext[15:0]), .q (outputPhaseTenths));
    scfg_field_reg #(.W(1), .RST(`SCFG_RST_BIT)) uAuto (
        .ref_clk (ref_clk), .rst (rst), .factory (factoryNow),
        .load (selAuto), .din (shiftNext[0]), .q (levelAutoOff));
    scfg_field_reg #(.W(1), .RST(`SCFG_RST_BIT)) uAlc (
        .ref_clk (ref_clk), .rst (rst), .factory (factoryNow),
        .load (selAlc), .din (shiftNext[0]), .q (levelingLoopSelect));
    scfg_field_reg #(.W(1), .RST(`SCFG_RST_MAIN_SLEEP)) uSleep (
        .ref_clk (ref_clk), .rst (rst), .factory (factoryNow),
        .load (selSleep), .din (shiftNext[0]), .q (mainChannelSleep));
    scfg_field_reg #(.W(2), .RST(`SCFG_RST_TB_SEL)) uTbSel (
        .ref_clk (ref_clk), .rst (rst), .factory (factoryNow),
        .load (selTbSel), .din (shiftNext[1:0]), .q (timebaseSelect));
    scfg_field_reg #(.W(14), .RST(`SCFG_RST_TRIM)) uTbTrim (
        .ref_clk (ref_clk), .rst (rst), .factory (factoryNow),
        .load (selTbTrim), .din (shiftNext[13:0]), .q (timebaseTrimValue));
    scfg_field_reg #(.W(14), .RST(`SCFG_RST_TRIM)) uAlcTrim (
        .ref_clk (ref_clk), .rst (rst), .factory (factoryNow),
        .load (selAlcTrim), .din (shiftNext[13:0]), .q (levelingTrimValue));
    scfg_field_reg #(.W(1), .RST(`SCFG_RST_CH2_SLEEP)) uCh2Sleep (
        .ref_clk (ref_clk), .rst (rst), .factory (factoryNow),
        .load (selCh2Slp), .din (shiftNext[0]), .q (secondChannelSleep));
    scfg_field_reg #(.W(16), .RST(`SCFG_RST_WORD16)) uCh2Mhz (
        .ref_clk (ref_clk), .rst (rst), .factory (factoryNow),
        .load (selCh2Mhz), .din (shiftNext[15:0]), .q (secondChannelToneMhz));

    // ------------------------------------------------------------
    // command strobes, one cycle each
    // ------------------------------------------------------------
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            listPointData       <= 40'h0000000000;
            listPointStrobe     <= 1'b0;
            listMemoryTransfer  <= 1'b0;
            listSoftwareTrigger <= 1'b0;
            savePowerOnState    <= 1'b0;
            restartKeep         <= 1'b0;
            restartFactory      <= 1'b0;
        end
        else
        begin
            listPointStrobe     <= selLoad;
            listMemoryTransfer  <= selXfer;
            listSoftwareTrigger <= selTrig;
            savePowerOnState    <= selSave;
            restartKeep         <= selRestart && !shiftNext[`SCFG_RESTART_MODE_BIT];
            restartFactory      <= selRestart && shiftNext[`SCFG_RESTART_MODE_BIT];
            if (selLoad)
                listPointData <= shiftNext;
        end
    end
    // write-only map: no read path for any register
endmodule
`default_nettype wire

// ### scfg_decoder_asserts.sv
// checker: byte stream to decoder output timing
// assumes: bound to scfg_decoder, one ref_clk domain
`timescale 1ns/10ps
`default_nettype none
module scfg_decoder_asserts
(
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        byteValid,
    input wire logic        frameStart,
    input wire logic        busy,
    input wire logic        toneOrSweepSelect,
    input wire logic        listPointStrobe,
    input wire logic        outputOnSwitch,
    input wire logic        restartKeep,
    input wire logic        restartFactory,
    input wire logic [7:0]  byteData,
    input wire logic [39:0] outputToneHz,
    input wire logic [39:0] listPointData
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    sequence addr_s(a, ok);
        byteValid && !frameStart && !busy && byteData == a && ok;
    endsequence
    sequence pay5_s;
        (byteValid && !frameStart) [*5];
    endsequence
    property load5_p(a, ok, v);
        addr_s(a, ok) ##1 pay5_s |=> v == {$past(byteData), $past(byteData, 2), $past(byteData, 3),
            $past(byteData, 4), $past(byteData, 5)};
    endproperty
    tone_load_a: assert property (load5_p(8'h10, !toneOrSweepSelect, outputToneHz))
        else $error("tone word wrong");
    point_load_a: assert property (load5_p(8'h0d, 1'b1, listPointData))
        else $error("point word wrong");
    point_pulse_a: assert property (addr_s(8'h0d, 1'b1) ##1 pay5_s |=> listPointStrobe ##1 !listPointStrobe)
        else $error("point strobe wrong");
    tone_frozen_a: assert property (toneOrSweepSelect && !restartFactory |=> $stable(outputToneHz))
        else $error("tone changed in sweep mode");
    out_on_a: assert property (addr_s(8'h12, 1'b1) ##1 (byteValid && !frameStart)
        |=> outputOnSwitch == $past(byteData[0]) && !busy) else $error("output switch wrong");
    keep_hold_a: assert property (restartKeep |=> $stable(outputToneHz) && $stable(outputOnSwitch))
        else $error("keep restart changed fields");
    factory_clear_a: assert property (restartFactory
        |=> outputToneHz == 40'h0 && outputOnSwitch && !toneOrSweepSelect) else $error("factory restart kept fields");
    abort_idle_a: assert property (frameStart |=> !busy)
        else $error("busy after abort");
endmodule
bind scfg_decoder scfg_decoder_asserts u_scfg_decoder_asserts (.ref_clk (ref_clk), .rst (rst),
    .byteValid (byteValid), .frameStart (frameStart), .busy (busy), .toneOrSweepSelect (toneOrSweepSelect),
    .listPointStrobe (listPointStrobe), .outputOnSwitch (outputOnSwitch), .restartKeep (restartKeep),
    .restartFactory (restartFactory), .byteData (byteData), .outputToneHz (outputToneHz),
    .listPointData (listPointData));
`default_nettype wire

// ### scfg_field_reg.v
// one write-only configuration field loaded from the assembled payload
// assumes: load is a one-cycle strobe on ref_clk
`timescale 1ns/10ps
`default_nettype none
module scfg_field_reg
#(
    parameter         W   = 8,
    parameter [W-1:0] RST = {W{1'b0}}
)
(
    input  wire         ref_clk,
    input  wire         rst,
    input  wire         factory,
    input  wire         load,
    input  wire [W-1:0] din,
    output reg  [W-1:0] q
);
    always @(posedge ref_clk)
    begin
        if (rst || factory)
            q <= RST;
        else if (load)
            q <= din;
    end
endmodule
`default_nettype wire

// ### scfg_host_model.sv
// host model: writes register frames onto the decoder byte stream
// assumes: shares ref_clk with the decoder, launches bytes just after rising edges
`timescale 1ns/10ps
`default_nettype none
module scfg_host_model
(
    input  wire logic       ref_clk,
    output var  logic       byteValid,
    output var  logic [7:0] byteData,
    output var  logic       frameStart
);
    int gap = 0;
    initial {byteValid, byteData, frameStart} = 10'h0b4;
    task automatic put(input logic [7:0] b);
        @(posedge ref_clk);
        {byteValid, byteData} <= {1'b1, b};
        repeat (gap) @(posedge ref_clk) {byteValid, byteData} <= {1'b0, ~b};
    endtask
    task automatic wr(input logic [7:0] a, input logic [39:0] v, input int n);
        put(a);
        for (int i = 0; i < n; i++)
            put(v[8*i+:8]);
        @(posedge ref_clk);
        {byteValid, byteData} <= {1'b0, ~byteData};
    endtask
    task automatic abort();
        @(posedge ref_clk);
        {byteValid, frameStart} <= 2'b01;
        @(posedge ref_clk);
        frameStart <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ### scfg_map.vh
// register addresses, payload lengths and reset values of the configuration map
// assumes: included by the decoder files only, by its bare name
// Operation
// - restart command bit 0 low keeps settings, high returns power-up state
// - one register map serves every host interface identically
// - list point load carries 40-bit hertz word, five bytes, one point each
// - output tone register holds 40-bit hertz word in five bytes
// - all configuration registers are write-only, nothing reads back
// - tone register writes ignored while sweep/list mode is selected
`ifndef SCFG_MAP_VH
`define SCFG_MAP_VH
`define SCFG_ADDR_RESTART     8'h01
`define SCFG_ADDR_TONE_MODE   8'h04
`define SCFG_ADDR_LIST_START  8'h06
`define SCFG_ADDR_LIST_STOP   8'h07
`define SCFG_ADDR_LIST_STEP   8'h08
`define SCFG_ADDR_LIST_DWELL  8'h09
`define SCFG_ADDR_LIST_CYCLES 8'h0a
`define SCFG_ADDR_LIST_RSV    8'h0b
`define SCFG_ADDR_LIST_COUNT  8'h0c
`define SCFG_ADDR_LIST_LOAD   8'h0d
`define SCFG_ADDR_LIST_XFER   8'h0e
`define SCFG_ADDR_LIST_TRIG   8'h0f
`define SCFG_ADDR_TONE_HZ     8'h10
`define SCFG_ADDR_POWER       8'h11
`define SCFG_ADDR_OUT_ON      8'h12
`define SCFG_ADDR_PHASE       8'h13
`define SCFG_ADDR_AUTO_OFF    8'h14
`define SCFG_ADDR_ALC_SEL     8'h15
`define SCFG_ADDR_MAIN_SLEEP  8'h16
`define SCFG_ADDR_TB_SEL      8'h17
`define SCFG_ADDR_TB_TRIM     8'h18
`define SCFG_ADDR_ALC_TRIM    8'h19
`define SCFG_ADDR_SPARE_1A    8'h1a
`define SCFG_ADDR_SAVE        8'h1b
`define SCFG_ADDR_SPARE_1C    8'h1c
`define SCFG_ADDR_SPARE_1D    8'h1d
`define SCFG_ADDR_CH2_SLEEP   8'h1e
`define SCFG_ADDR_CH2_MHZ     8'h1f
`define SCFG_LEN_1            3'h1
`define SCFG_LEN_2            3'h2
`define SCFG_LEN_4            3'h4
`define SCFG_LEN_5            3'h5
`define SCFG_RESTART_MODE_BIT 0
`define SCFG_RST_TONE_HZ      40'h0000000000
`define SCFG_RST_WORD16       16'h0000
`define SCFG_RST_OUT_ON       1'b1
`define SCFG_RST_MAIN_SLEEP   1'b0
`define SCFG_RST_CH2_SLEEP    1'b1
`define SCFG_RST_BIT          1'b0
`define SCFG_RST_TB_SEL       2'h0
`define SCFG_RST_TRIM         14'h0000
`endif

// ### test_synth_config_register_map.sv
// testbench: register frames from the host model, decoder outputs compared
// assumes: decoder, host model and checker compiled before this file
`timescale 1ns/10ps
`default_nettype none
module test_synth_config_register_map;
    logic        ref_clk = 1'b0, rst = 1'b1, byteValid, frameStart, byteReady, busy, toneOrSweepSelect;
    logic        listPointStrobe, listMemoryTransfer, listSoftwareTrigger, outputOnSwitch, levelAutoOff;
    logic        levelingLoopSelect, mainChannelSleep, savePowerOnState, secondChannelSleep, restartKeep, restartFactory;
    logic [7:0]  byteData;
    logic [39:0] outputToneHz, listPointData, lastPt;
    logic [15:0] listPointCount, outputPowerLevel, outputPhaseTenths, secondChannelToneMhz;
    logic [13:0] timebaseTrimValue, levelingTrimValue;
    logic [1:0]  timebaseSelect;
    int          miscompares = 0, checks = 0, nPt = 0, nOne = 0, nF = 0;
    logic [15:0] w1 [13] = '{16'h0b00, 16'h1200, 16'h1a00, 16'h1601, 16'h1c00, 16'h1e00, 16'h1d00,
                             16'h1702, 16'h1401, 16'h1501, 16'h0e01, 16'h0f00, 16'h1b00};
    logic [23:0] w2 [6] = '{24'h0cbeef, 24'h118123, 24'h137e01, 24'h182abc, 24'h191234, 24'h1fcafe};
    scfg_host_model u_scfg_host_model (.ref_clk (ref_clk), .byteValid (byteValid), .byteData (byteData),
        .frameStart (frameStart));
    scfg_decoder u_scfg_decoder (.ref_clk (ref_clk), .rst (rst), .byteValid (byteValid), .byteData (byteData),
        .frameStart (frameStart), .byteReady (byteReady), .busy (busy), .outputToneHz (outputToneHz),
        .toneOrSweepSelect (toneOrSweepSelect), .listPointCount (listPointCount), .listPointData (listPointData),
        .listPointStrobe (listPointStrobe), .listMemoryTransfer (listMemoryTransfer),
        .listSoftwareTrigger (listSoftwareTrigger), .outputPowerLevel (outputPowerLevel),
        .outputOnSwitch (outputOnSwitch), .outputPhaseTenths (outputPhaseTenths), .levelAutoOff (levelAutoOff),
        .levelingLoopSelect (levelingLoopSelect), .mainChannelSleep (mainChannelSleep),
        .timebaseSelect (timebaseSelect), .timebaseTrimValue (timebaseTrimValue),
        .levelingTrimValue (levelingTrimValue), .savePowerOnState (savePowerOnState),
        .secondChannelSleep (secondChannelSleep), .secondChannelToneMhz (secondChannelToneMhz),
        .restartKeep (restartKeep), .restartFactory (restartFactory));
    initial forever #20 ref_clk = ~ref_clk;
    // pulse counters
    always @(posedge ref_clk)
    begin
        nPt += listPointStrobe;
        nOne += listMemoryTransfer + 2 * listSoftwareTrigger + 4 * savePowerOnState + 8 * restartKeep;
        nF += restartFactory;
        if (listPointStrobe)
            lastPt = listPointData;
    end
    task automatic chk(input string nm, input logic [95:0] exp, got);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [39:0] v, input int n);
        u_scfg_host_model.wr(a, v, n);
        repeat (2) @(negedge ref_clk);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(negedge ref_clk);
        chk("reset", {40'h0, 5'b10110}, {outputToneHz, outputOnSwitch, mainChannelSleep, secondChannelSleep,
            byteReady, busy});
        wr(8'h10, 40'h123456789a, 5);
        chk("tone", 40'h123456789a, outputToneHz);
        u_scfg_host_model.gap = 1;
        wr(8'h0d, 40'h9abcdef012, 5);
        chk("slow point", 40'h9abcdef012, lastPt);
        u_scfg_host_model.gap = 0;
        wr(8'h0d, 40'h0102030405, 5);
        chk("points", {8'd2, 40'h0102030405}, {nPt[7:0], lastPt});
        foreach (w2[i])
            wr(w2[i][23:16], w2[i][15:0], 2);
        foreach (w1[i])
            wr(w1[i][15:8], w1[i][7:0], 1);
        chk("words", {16'hbeef, 16'h8123, 16'h7e01, 14'h2abc, 14'h1234, 16'hcafe}, {listPointCount,
            outputPowerLevel, outputPhaseTenths, timebaseTrimValue, levelingTrimValue, secondChannelToneMhz});
        chk("bits", 7'b0101011, {outputOnSwitch, mainChannelSleep, secondChannelSleep, timebaseSelect,
            levelAutoOff, levelingLoopSelect});
        wr(8'h04, 8'h01, 1);
        wr(8'h10, 40'h5555555555, 5);
        chk("frozen", {1'b1, 40'h123456789a}, {toneOrSweepSelect, outputToneHz});
        wr(8'h04, 8'h00, 1);
        u_scfg_host_model.put(8'h11);
        u_scfg_host_model.put(8'h00);
        @(negedge ref_clk);
        chk("busy", 2'b11, {busy, byteReady});
        u_scfg_host_model.abort();
        wr(8'h12, 8'h01, 1);
        chk("abort", {1'b1, 16'h8123}, {outputOnSwitch, outputPowerLevel});
        wr(8'h01, 8'h00, 1);
        chk("keep", {8'd15, 8'd0, 41'h1123456789a}, {nOne[7:0], nF[7:0], outputOnSwitch, outputToneHz});
        wr(8'h01, 8'h01, 1);
        chk("factory", {8'd1, 40'h0, 3'b101, 16'h0}, {nF[7:0], outputToneHz, outputOnSwitch,
            mainChannelSleep, secondChannelSleep, outputPowerLevel});
        tally_and_finish();
    end
endmodule
`default_nettype wire
